// ==== src/adc_trig_ref_pkg.sv ====
// package: register map, field layout and select encodings of the trigger/reference control
package adc_trig_ref_pkg;
	localparam int          addr_w           = 4;
	localparam logic [3:0]  ctrl_reg_addr    = 4'h0;
	localparam int          data_w           = 32;
	localparam int          reg_w            = 8;
	localparam logic [7:0]  ctrl_reset_val   = 8'h00;
	localparam logic [7:0]  ctrl_write_mask  = 8'h8f;
	localparam int          trig_sel_bit     = 7;
	localparam int          pos_ref_lsb      = 2;
	localparam int          neg_ref_lsb      = 0;
	localparam logic [31:0] unmapped_rd_val  = 32'h0000_0000;
	// positive reference select codes
	localparam logic [1:0]  pref_supply      = 2'h0;
	localparam logic [1:0]  pref_ext_pin     = 2'h1;
	localparam logic [1:0]  pref_fixed_buf2  = 2'h2;
	localparam logic [1:0]  pref_reserved    = 2'h3;
	// negative reference select codes
	localparam logic [1:0]  nref_ground      = 2'h0;
	localparam logic [1:0]  nref_ext_pin     = 2'h1;
	// one-hot routing outputs
	localparam logic [2:0]  pos_sel_supply   = 3'h1;
	localparam logic [2:0]  pos_sel_ext      = 3'h2;
	localparam logic [2:0]  pos_sel_buf2     = 3'h4;
	localparam logic [1:0]  neg_sel_ground   = 2'h1;
	localparam logic [1:0]  neg_sel_ext      = 2'h2;
	// bus slave phases
	typedef enum logic [1:0] {
		bus_idle = 2'h1,
		bus_done = 2'h2
	} bus_state_t;
endpackage

// ==== src/ref_route_decode.sv ====
// reference and trigger routing decode of the control register fields
`timescale 1ns/1ps
`default_nettype none
module ref_route_decode
	import adc_trig_ref_pkg::*;
(
	input  wire logic [1:0] positive_reference_config_in, // positive reference code
	input  wire logic [1:0] negative_reference_config_in, // negative reference code
	input  wire logic       special_trigger_source_select_in, // trigger source bit
	input  wire logic       charge_time_unit_trig_in,     // trigger from charge-time unit
	input  wire logic       capture_compare_unit_five_trig_in, // trigger from ccp five
	output logic      [2:0] pos_sel_out,                  // one-hot positive routing
	output logic      [1:0] neg_sel_out,                  // one-hot negative routing
	output logic            special_trigger_out           // selected trigger
);
	wire logic pos_is_ext;
	wire logic pos_is_buf2;
	wire logic neg_is_ext;
	assign pos_is_ext  = (positive_reference_config_in == pref_ext_pin);
	assign pos_is_buf2 = (positive_reference_config_in == pref_fixed_buf2);
	// code 11 falls through to the supply like code 00
	assign pos_sel_out = pos_is_ext ? pos_sel_ext : (pos_is_buf2 ? pos_sel_buf2 : pos_sel_supply);
	assign neg_is_ext  = (negative_reference_config_in == nref_ext_pin);
	// codes 10 and 11 fall through to ground
	assign neg_sel_out = neg_is_ext ? neg_sel_ext : neg_sel_ground;
	assign special_trigger_out = special_trigger_source_select_in ? charge_time_unit_trig_in
		: capture_compare_unit_five_trig_in;
endmodule
`default_nettype wire

// ==== src/adc_trigger_reference_select.sv ====
// converter trigger source and reference select register with avalon-mm slave
// Function
// - bit 7: one picks charge-time unit trigger
// - positive ref: supply, external pin, buffer two
// - positive code 11 acts as supply
// - negative ref: ground or external pin
// - negative codes 10, 11 act as ground
//
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module adc_trigger_reference_select
	import adc_trig_ref_pkg::*;
(
	input  wire logic                            core_clk_in,        // 10 MHz clock
	input  wire logic                            reset_n_in,         // async reset, active low
	input  wire logic                            clk_en_in,          // freezes all state when low
	input  wire logic [adc_trig_ref_pkg::addr_w-1:0] avs_address_in, // word address
	input  wire logic                            avs_read_in,        // read request
	input  wire logic                            avs_write_in,       // write request
	input  wire logic [3:0]                      avs_byteenable_in,  // byte enables
	input  wire logic [adc_trig_ref_pkg::data_w-1:0] avs_writedata_in, // write data
	output logic      [adc_trig_ref_pkg::data_w-1:0] avs_readdata_out, // read data
	output logic                                 avs_waitrequest_out, // stall
	input  wire logic                            charge_time_unit_trig_in, // trigger source one
	input  wire logic                            capture_compare_unit_five_trig_in, // source two
	output logic                                 special_trigger_out, // routed trigger
	output logic      [2:0]                      pos_ref_sel_out,    // supply/ext/buf2 one-hot
	output logic      [1:0]                      neg_ref_sel_out     // ground/ext one-hot
);
	import adc_trig_ref_pkg::*;

	logic [reg_w-1:0]  ctrl_ff;
	logic [reg_w-1:0]  nxt_ctrl;
	bus_state_t        bus_ff;
	bus_state_t        nxt_bus;
	logic [data_w-1:0] rdata_ff;
	logic [data_w-1:0] nxt_rdata;
	logic              trig_a_ff;
	logic              trig_b_ff;
	logic              trig_a2_ff;
	logic              trig_b2_ff;
	logic              trig_ff;
	logic [2:0]        pos_ff;
	logic [1:0]        neg_ff;
	wire logic [2:0]   pos_dec;
	wire logic [1:0]   neg_dec;
	wire logic         trig_dec;
	wire logic         req;
	wire logic         hit;
	wire logic         wr_take;
	wire logic [data_w-1:0] rd_word;

	assign req     = avs_read_in | avs_write_in;
	assign hit     = (avs_address_in == ctrl_reg_addr);
	// a write lands while the request is still held and waitrequest is low
	assign wr_take = clk_en_in && avs_write_in && hit && (bus_ff == bus_done) && avs_byteenable_in[0];
	// unimplemented bits masked off on write and read back as zero
	assign nxt_ctrl = wr_take ? (avs_writedata_in[reg_w-1:0] & ctrl_write_mask) : ctrl_ff;
	assign rd_word  = hit ? {{(data_w-reg_w){1'b0}}, ctrl_ff & ctrl_write_mask} : unmapped_rd_val;
	assign nxt_rdata = (bus_ff == bus_idle && avs_read_in) ? rd_word : rdata_ff;

	always_comb begin
		nxt_bus = bus_ff;
		unique case (bus_ff)
			bus_idle: begin
				if (req) begin
					nxt_bus = bus_done;
				end
			end
			bus_done: begin
				nxt_bus = bus_idle;
			end
			default: begin
				nxt_bus = bus_idle;
			end
		endcase
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ctrl_ff  <= ctrl_reset_val;
			bus_ff   <= bus_idle;
			rdata_ff <= unmapped_rd_val;
		end else if (clk_en_in) begin
			ctrl_ff  <= nxt_ctrl;
			bus_ff   <= nxt_bus;
			rdata_ff <= nxt_rdata;
		end
	end

	// waitrequest is high except in the answer cycle
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			avs_waitrequest_out <= 1'b1;
		end else if (clk_en_in) begin
			avs_waitrequest_out <= !(bus_ff == bus_idle && req);
		end
	end
	assign avs_readdata_out = rdata_ff;

	// trigger inputs come from other logic; synchronised in case of another clock
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			trig_a_ff  <= 1'b0;
			trig_b_ff  <= 1'b0;
			trig_a2_ff <= 1'b0;
			trig_b2_ff <= 1'b0;
		end else if (clk_en_in) begin
			trig_a_ff  <= charge_time_unit_trig_in;
			trig_b_ff  <= capture_compare_unit_five_trig_in;
			trig_a2_ff <= trig_a_ff;
			trig_b2_ff <= trig_b_ff;
		end
	end

	ref_route_decode u_decode (
		.positive_reference_config_in      (ctrl_ff[pos_ref_lsb+1:pos_ref_lsb]),
		.negative_reference_config_in      (ctrl_ff[neg_ref_lsb+1:neg_ref_lsb]),
		.special_trigger_source_select_in  (ctrl_ff[trig_sel_bit]),
		.charge_time_unit_trig_in          (trig_a2_ff),
		.capture_compare_unit_five_trig_in (trig_b2_ff),
		.pos_sel_out                       (pos_dec),
		.neg_sel_out                       (neg_dec),
		.special_trigger_out               (trig_dec)
	);

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			trig_ff <= 1'b0;
			pos_ff  <= pos_sel_supply;
			neg_ff  <= neg_sel_ground;
		end else if (clk_en_in) begin
			trig_ff <= trig_dec;
			pos_ff  <= pos_dec;
			neg_ff  <= neg_dec;
		end
	end
	assign special_trigger_out = trig_ff;
	assign pos_ref_sel_out     = pos_ff;
	assign neg_ref_sel_out     = neg_ff;

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!reset_n_in);

	a_trig_charge_time_unit_route: assert property (clk_en_in && ctrl_ff[trig_sel_bit] && $stable(ctrl_ff)
		|=> special_trigger_out == $past(trig_a2_ff))
		else $error("trigger not taken from charge-time unit");
	a_trig_ccp_route: assert property (clk_en_in && !ctrl_ff[trig_sel_bit] && $stable(ctrl_ff)
		|=> special_trigger_out == $past(trig_b2_ff))
		else $error("trigger not taken from capture compare five");
	a_pos_ext_sel: assert property (clk_en_in && ctrl_ff[3:2] == pref_ext_pin
		|=> pos_ref_sel_out == pos_sel_ext)
		else $error("positive ref not on external pin");
	a_pos_buf2_sel: assert property (clk_en_in && ctrl_ff[3:2] == pref_fixed_buf2
		|=> pos_ref_sel_out == pos_sel_buf2)
		else $error("positive ref not on buffer two");
	a_pos_reserved_supply: assert property (clk_en_in && (ctrl_ff[3:2] == pref_reserved
		|| ctrl_ff[3:2] == pref_supply) |=> pos_ref_sel_out == pos_sel_supply)
		else $error("positive ref not on supply");
	a_neg_ext_sel: assert property (clk_en_in && ctrl_ff[1:0] == nref_ext_pin
		|=> neg_ref_sel_out == neg_sel_ext)
		else $error("negative ref not on external pin");
	a_neg_reserved_gnd: assert property (clk_en_in && ctrl_ff[1:0] != nref_ext_pin
		|=> neg_ref_sel_out == neg_sel_ground)
		else $error("negative ref not on ground");
	a_unimpl_zero: assert property (ctrl_ff[6:4] == 3'h0)
		else $error("unimplemented bits not zero");
	a_write_lands: assert property (wr_take |=> ctrl_ff == ($past(avs_writedata_in[7:0])
		& ctrl_write_mask))
		else $error("write value not stored");
	a_read_answer: assert property (clk_en_in && avs_read_in && hit && bus_ff == bus_idle
		|=> !avs_waitrequest_out && avs_readdata_out[7:0] == $past(ctrl_ff))
		else $error("read answer wrong");
	a_unmapped_read: assert property (clk_en_in && avs_read_in && !hit && bus_ff == bus_idle
		|=> avs_readdata_out == unmapped_rd_val)
		else $error("unmapped read not zero");
	a_freeze_hold: assert property (!clk_en_in
		|=> $stable(ctrl_ff) && $stable(avs_waitrequest_out) && $stable(pos_ref_sel_out))
		else $error("state moved while clock enable low");
	a_wait_one_cycle: assert property (clk_en_in && !avs_waitrequest_out
		|=> avs_waitrequest_out)
		else $error("waitrequest low for more than one cycle");

	c_write_reg: cover property (wr_take);
	c_read_reg: cover property (avs_read_in && !avs_waitrequest_out);
	c_pos_reserved: cover property (ctrl_ff[3:2] == pref_reserved);
	c_trig_charge_time_unit: cover property (ctrl_ff[trig_sel_bit] && special_trigger_out);
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// self-checking testbench of the trigger and reference select register
`timescale 1ns/1ps
`default_nettype none
module tb;
	import adc_trig_ref_pkg::*;
	logic              core_clk_in = 1'b0;
	logic              reset_n_in  = 1'b0;
	logic              clk_en_in   = 1'b1;
	logic [addr_w-1:0] address     = '0;
	logic              rd          = 1'b0;
	logic              wr          = 1'b0;
	logic [3:0]        be          = 4'h0;
	logic [data_w-1:0] wdata       = '0;
	logic              ctu_trig    = 1'b0;
	logic              ccp_trig    = 1'b0;
	wire  [data_w-1:0] rdata;
	wire               wait_rq;
	wire               trig;
	wire  [2:0]        pos_sel;
	wire  [1:0]        neg_sel;
	int                error_cnt   = 0;
	int                checks      = 0;
	int                cycles      = 0;
	always #50 core_clk_in = ~core_clk_in;
	adc_trigger_reference_select u_adc_trigger_reference_select (
		.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
		.avs_address_in(address), .avs_read_in(rd), .avs_write_in(wr),
		.avs_byteenable_in(be), .avs_writedata_in(wdata), .avs_readdata_out(rdata),
		.avs_waitrequest_out(wait_rq), .charge_time_unit_trig_in(ctu_trig),
		.capture_compare_unit_five_trig_in(ccp_trig), .special_trigger_out(trig),
		.pos_ref_sel_out(pos_sel), .neg_ref_sel_out(neg_sel));
	task automatic close_out();
		$display("comparisons %0d, mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask
	// one avalon cycle; held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [addr_w-1:0] a, input logic [31:0] d,
			input logic [3:0] b, output logic [31:0] q);
		@(posedge core_clk_in);
		address <= a;
		wr <= w;
		rd <= ~w;
		wdata <= d;
		be <= b;
		do @(posedge core_clk_in); while (wait_rq !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	function automatic logic [2:0] pos_exp(input logic [1:0] c);
		return (c == 2'h1) ? pos_sel_ext : (c == 2'h2) ? pos_sel_buf2 : pos_sel_supply;
	endfunction
	task automatic t_idle(input logic [31:0] reg_exp);
		logic [31:0] q;
		bus(1'b0, ctrl_reg_addr, 32'h0, 4'hf, q);
		chk("control", q, reg_exp);
		chk("positive", {29'h0, pos_sel}, {29'h0, pos_sel_supply});
		chk("negative", {30'h0, neg_sel}, {30'h0, neg_sel_ground});
	endtask
	task automatic t_refuse();
		logic [31:0] q;
		bus(1'b1, ctrl_reg_addr, 32'h8f, 4'he, q);
		bus(1'b1, 4'h1, 32'h8f, 4'h1, q);
		bus(1'b0, 4'h1, 32'h0, 4'hf, q);
		chk("unmapped", q, 32'h0);
		t_idle(32'h0);
	endtask
	// clock enable low must hold the bus answer back until it rises
	task automatic t_freeze();
		@(posedge core_clk_in);
		clk_en_in <= 1'b0;
		address <= ctrl_reg_addr;
		rd <= 1'b1;
		repeat (4) @(posedge core_clk_in);
		chk("frozen wait", {31'h0, wait_rq}, 32'h1);
		clk_en_in <= 1'b1;
		do @(posedge core_clk_in); while (wait_rq !== 1'b0);
		chk("frozen read", rdata, 32'h0);
		rd <= 1'b0;
	endtask
	task automatic t_fields();
		logic [31:0] q;
		for (int i = 0; i < 16; i++) begin
			bus(1'b1, ctrl_reg_addr, {24'h0, i[0], 3'h7, i[3:0]}, 4'h1, q);
			bus(1'b0, ctrl_reg_addr, 32'h0, 4'hf, q);
			chk("control", q, {24'h0, i[0], 3'h0, i[3:0]});
			chk("positive", {29'h0, pos_sel}, {29'h0, pos_exp(i[3:2])});
			chk("negative", {30'h0, neg_sel},
				{30'h0, (i[1:0] == 2'h1) ? neg_sel_ext : neg_sel_ground});
			ctu_trig <= 1'b1;
			ccp_trig <= 1'b0;
			repeat (5) @(negedge core_clk_in);
			chk("trigger", {31'h0, trig}, {31'h0, i[0]});
			ctu_trig <= 1'b0;
			ccp_trig <= 1'b1;
			repeat (5) @(negedge core_clk_in);
			chk("trigger", {31'h0, trig}, {31'h0, ~i[0]});
		end
	endtask
	task automatic t_rereset();
		logic [31:0] q;
		bus(1'b1, ctrl_reg_addr, 32'h85, 4'h1, q);
		reset_n_in <= 1'b0;
		repeat (3) @(posedge core_clk_in);
		reset_n_in <= 1'b1;
		t_idle(32'h0);
	endtask
	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			close_out();
		end
	end
	initial begin
		repeat (20) @(posedge core_clk_in);
		reset_n_in <= 1'b1;
		t_idle(32'h0);
		t_refuse();
		t_freeze();
		t_fields();
		t_rereset();
		close_out();
	end
endmodule
`default_nettype wire
